// file: hw/cvip_arbiter.sv
`timescale 1ns/1ps
// =============================================================
// Priority resolver for one controller
// =============================================================
module cvip_arbiter
(
    input  wire logic [7:0] req,
    input  wire logic [7:0] in_service_vector,
    input  wire logic [7:0] mask,
    input  wire logic [2:0] lowPri,
    output logic            valid,
    output logic [2:0]      idx
);
    import cvip_pkg::*;

    // Walk from highest priority down; an in-service level stops the walk
    always_comb
    begin
        logic [2:0] p;
        logic       stop;
        p = 3'h0;
        stop = 1'b0;
        valid = 1'b0;
        idx = SPURIOUS_IDX;
        for (int k = 1; k <= 8; k++)
        begin
            p = lowPri + 3'(k);
            if (!stop)
            begin
                if (in_service_vector[p])
                begin
                    stop = 1'b1;
                end
                else if (req[p] && !mask[p])
                begin
                    valid = 1'b1;
                    idx = p;
                    stop = 1'b1;
                end
            end
        end
    end

endmodule : cvip_arbiter

// file: hw/cvip_pair.sv
`timescale 1ns/1ps
// =============================================================
// Cascaded vectored interrupt controller pair
// =============================================================
// Contract
// - Respond only when A7-A4 match switches
// - Master at offsets 0-1, slave 2-3
// - Offsets 8-11, 13/15 writes left undecoded
// - Master input 1 is the slave's request
// - Bus lines except VI1 feed master, cascadable externally
// - Slave inputs: timers, serial, parallel, VI1
// - Raise request; three pulses give call, address
// - First pulse: call opcode, resolve, cascade; cascade address is driven on the second and third pulses only
// - Address low byte, then high byte
// - Routine addresses equally spaced from port_block_origin
// - Interval four or eight sets generated bits
// - Two-pulse first pulse drives no data
// - Two-pulse type byte: programmed top, input
// - Priority commands accepted at any time
// - Fully nested default; in-service blocks lower
// - Acknowledge sets in-service until done command
// - Automatic done clears at last pulse end
// - Jumper setting; no-drive disables address cascading
module cvip_pair
(
    input  wire logic [3:0] boardAddressSwitch,
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic [7:0] ioAddr,
    input  wire logic [7:0] ioWrData,
    input  wire logic       ioWr,
    input  wire logic       ioRd,
    output logic [7:0]      ioRdData,
    output logic            ioRdOe_n,
    input  wire logic [7:0] vectorLines,
    input  wire logic       timerOutputTwo,
    input  wire logic       timerOutputThree,
    input  wire logic       timerOutputFour,
    input  wire logic       receiveReadyFlag,
    input  wire logic       parReceiveReadyFlag,
    input  wire logic       transmitReadyFlag,
    input  wire logic       parTransmitReadyFlag,
    input  wire logic [1:0] ackCfg,
    input  wire logic       intaN,
    output logic            intReq,
    output logic [7:0]      ackData,
    output logic            ackDataOe_n,
    output logic [2:0]      cascAddr,
    output logic            cascAddrOe_n
);
    import cvip_pkg::*;

    // =========================================================
    // Address decode
    // =========================================================
    logic       boardHit;
    logic       ctrlHit;
    logic       ctrlSel;
    logic       portSel;
    logic [1:0] wrEn;

    assign boardHit = (ioAddr[7:4] == boardAddressSwitch);
    // Only the four controller ports decode; all else stays free
    assign ctrlHit  = boardHit && (ioAddr[3:2] == MASTER_CTRL_PORT_LO[3:2]);
    assign ctrlSel  = (ioAddr[3:0] >= ONBOARD_SLAVE_PORT_LO);
    assign portSel  = ioAddr[0];
    assign wrEn[0]  = ioWr && ctrlHit && !ctrlSel;
    assign wrEn[1]  = ioWr && ctrlHit && ctrlSel;

    // =========================================================
    // Controller state
    // =========================================================
    cvip_cfg_s  cfg_q      [2];
    cvip_init_e initSt_q   [2];
    logic [7:0] isr_q      [2];
    logic [7:0] mask_q     [2];
    logic [2:0] lowPri_q   [2];
    logic       rotAeoi_q  [2];
    logic       readIsr_q  [2];
    logic [7:0] pending_request_vector        [2];
    logic       pickValid  [2];
    logic [2:0] pickIdx    [2];
    logic [3:0] topIsr     [2];

    // Request routing
    assign pending_request_vector[1] = {timerOutputFour, parTransmitReadyFlag, transmitReadyFlag,
                     timerOutputThree, vectorLines[1], parReceiveReadyFlag,
                     receiveReadyFlag, timerOutputTwo};
    // Input 1 of the master is the slave's request only
    assign pending_request_vector[0] = {vectorLines[7:2], pickValid[1], vectorLines[0]};

    cvip_arbiter u_arbMaster
    (
        .req    (pending_request_vector[0]),
        .in_service_vector    (isr_q[0]),
        .mask   (mask_q[0]),
        .lowPri (lowPri_q[0]),
        .valid  (pickValid[0]),
        .idx    (pickIdx[0])
    );

    cvip_arbiter u_arbSlave
    (
        .req    (pending_request_vector[1]),
        .in_service_vector    (isr_q[1]),
        .mask   (mask_q[1]),
        .lowPri (lowPri_q[1]),
        .valid  (pickValid[1]),
        .idx    (pickIdx[1])
    );

    assign topIsr[0] = cvip_top_isr(isr_q[0], lowPri_q[0]);
    assign topIsr[1] = cvip_top_isr(isr_q[1], lowPri_q[1]);

    // Request to the processor is held back while the master's set-up sequence is in progress
    assign intReq = pickValid[0] && (initSt_q[0] == INIT_READY);

    // =========================================================
    // Acknowledge sequencing
    // =========================================================
    logic       intaPrev_q;
    logic [1:0] ackCnt_q;
    logic [2:0] mIdx_q;
    logic       mValid_q;
    logic [2:0] sIdx_q;
    logic       sValid_q;
    logic       viaSlave_q;
    logic       ackLead;
    logic       ackTrail;
    logic       firstLead;
    logic [1:0] lastCnt;
    logic       lastTrail;
    logic       viaSlave;
    logic       extSlave;
    logic       busDrive;
    logic [2:0] vecIdx;
    cvip_cfg_s  vecCfg;
    logic [7:0] vecByte;
    logic       dataDrive;

    assign ackLead   = !intaN && intaPrev_q;
    assign ackTrail  = intaN && !intaPrev_q;
    assign firstLead = ackLead && (ackCnt_q == 2'h0);
    // Sequence length follows the master's programmed mode
    assign lastCnt   = cfg_q[0].twoPulse ? 2'h1 : 2'h2;
    assign lastTrail = ackTrail && (ackCnt_q == lastCnt);
    assign viaSlave  = firstLead ? (pickValid[0] && pickIdx[0] == SLAVE_INPUT)
                                 : viaSlave_q;
    assign busDrive  = (ackCfg != ACKCFG_NODRV);
    // A master input marked cascaded hands data to a board on the bus
    assign extSlave  = !viaSlave && mValid_q && !cfg_q[0].single
                       && cfg_q[0].cascIn[mIdx_q] && busDrive;
    assign vecCfg    = viaSlave_q ? cfg_q[1] : cfg_q[0];
    assign vecIdx    = viaSlave_q ? (sValid_q ? sIdx_q : SPURIOUS_IDX)
                                  : (mValid_q ? mIdx_q : SPURIOUS_IDX);

    cvip_vector_fmt u_vecFmt
    (
        .cfg     (vecCfg),
        .idx     (vecIdx),
        .byteNum (ackCnt_q),
        .vecByte (vecByte)
    );

    // Data drive per pulse; call opcode comes from the master alone
    always_comb
    begin
        dataDrive = 1'b0;
        if (!intaN)
        begin
            if (cfg_q[0].twoPulse)
                dataDrive = (ackCnt_q == 2'h1) && !extSlave;
            else
                dataDrive = (ackCnt_q == 2'h0) || !extSlave;
        end
    end

    // Pulse edge tracking
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            intaPrev_q <= 1'b1;
        else
            intaPrev_q <= intaN;
    end

    // Pulse counter; a stray pulse past the last restarts the sequence
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            ackCnt_q <= 2'h0;
        else if (lastTrail)
            ackCnt_q <= 2'h0;
        else if (ackTrail)
            ackCnt_q <= ackCnt_q + 2'h1;
    end

    // Freeze the winners at the first pulse
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mIdx_q     <= SPURIOUS_IDX;
            mValid_q   <= 1'b0;
            sIdx_q     <= SPURIOUS_IDX;
            sValid_q   <= 1'b0;
            viaSlave_q <= 1'b0;
        end
        else if (firstLead)
        begin
            mIdx_q     <= pickIdx[0];
            mValid_q   <= pickValid[0];
            sIdx_q     <= pickIdx[1];
            sValid_q   <= pickValid[1];
            viaSlave_q <= viaSlave;
        end
    end

    // Data and cascade outputs, registered one cycle behind the pulse
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ackData      <= 8'h00;
            ackDataOe_n  <= 1'b1;
            cascAddr     <= 3'h0;
            cascAddrOe_n <= 1'b1;
        end
        else
        begin
            ackData      <= vecByte;
            ackDataOe_n  <= !dataDrive;
            cascAddr     <= mIdx_q;
            cascAddrOe_n <= !(!intaN && ackCnt_q != 2'h0 && extSlave);
        end
    end

    // =========================================================
    // Programming, priority commands and in-service bits
    // =========================================================
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int c = 0; c < 2; c++)
            begin
                cfg_q[c]     <= '0;
                initSt_q[c]  <= INIT_READY;
                isr_q[c]     <= 8'h00;
                mask_q[c]    <= MASK_RESET;
                lowPri_q[c]  <= LOWPRI_RESET;
                rotAeoi_q[c] <= 1'b0;
                readIsr_q[c] <= 1'b0;
            end
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                logic [7:0] isrN;
                logic       take;
                isrN = isr_q[c];
                take = (c == 0) || viaSlave;
                // Automatic done at the trailing edge of the last pulse
                if (lastTrail && cfg_q[c].aeoi && topIsr[c][3] && (c == 0 || viaSlave_q))
                begin
                    isrN = isrN & ~cvip_one_hot(topIsr[c][2:0]);
                    if (rotAeoi_q[c])
                        lowPri_q[c] <= topIsr[c][2:0];
                end
                if (wrEn[c] && !portSel && ioWrData[CMD_INIT_BIT])
                begin
                    // Initialisation restores fully nested order
                    cfg_q[c].vecLo     <= ioWrData[7:5];
                    cfg_q[c].interval4 <= ioWrData[INIT_INTERVAL4];
                    cfg_q[c].single    <= ioWrData[INIT_SINGLE];
                    cfg_q[c].needW4    <= ioWrData[INIT_NEEDW4];
                    cfg_q[c].twoPulse  <= 1'b0;
                    cfg_q[c].aeoi      <= 1'b0;
                    initSt_q[c]        <= INIT_WANT2;
                    isrN               = 8'h00;
                    mask_q[c]          <= MASK_RESET;
                    lowPri_q[c]        <= LOWPRI_RESET;
                    rotAeoi_q[c]       <= 1'b0;
                    readIsr_q[c]       <= 1'b0;
                end
                else if (wrEn[c] && !portSel && ioWrData[CMD_SELECT_BIT])
                begin
                    if (ioWrData[READ_ENABLE])
                        readIsr_q[c] <= ioWrData[READ_INSERVICE];
                end
                else if (wrEn[c] && !portSel)
                begin
                    // Priority commands, legal at any time
                    unique case (ioWrData[7:5])
                        PRI_EOI_NONSPEC: isrN = isrN & ~cvip_one_hot(topIsr[c][2:0]);
                        PRI_ROT_NONSPEC:
                        begin
                            isrN = isrN & ~cvip_one_hot(topIsr[c][2:0]);
                            if (topIsr[c][3])
                                lowPri_q[c] <= topIsr[c][2:0];
                        end
                        PRI_EOI_SPEC:    isrN = isrN & ~cvip_one_hot(ioWrData[2:0]);
                        PRI_ROT_SPEC:
                        begin
                            isrN = isrN & ~cvip_one_hot(ioWrData[2:0]);
                            lowPri_q[c] <= ioWrData[2:0];
                        end
                        PRI_SET:          lowPri_q[c] <= ioWrData[2:0];
                        PRI_AEOI_ROT_ON:  rotAeoi_q[c] <= 1'b1;
                        PRI_AEOI_ROT_OFF: rotAeoi_q[c] <= 1'b0;
                        default:          isrN = isrN;
                    endcase
                end
                else if (wrEn[c] && portSel)
                begin
                    unique case (initSt_q[c])
                        INIT_WANT2:
                        begin
                            cfg_q[c].vecHi <= ioWrData;
                            if (!cfg_q[c].single)
                                initSt_q[c] <= INIT_WANT3;
                            else if (cfg_q[c].needW4)
                                initSt_q[c] <= INIT_WANT4;
                            else
                                initSt_q[c] <= INIT_READY;
                        end
                        INIT_WANT3:
                        begin
                            cfg_q[c].cascIn <= ioWrData;
                            initSt_q[c] <= cfg_q[c].needW4 ? INIT_WANT4 : INIT_READY;
                        end
                        INIT_WANT4:
                        begin
                            cfg_q[c].twoPulse <= ioWrData[MODE_TWOPULSE];
                            cfg_q[c].aeoi     <= ioWrData[MODE_AEOI];
                            initSt_q[c]       <= INIT_READY;
                        end
                        INIT_READY: mask_q[c] <= ioWrData;
                    endcase
                end
                // Set after clear, so a same-cycle acknowledge is kept
                if (firstLead && take && pickValid[c])
                    isrN = isrN | cvip_one_hot(pickIdx[c]);
                isr_q[c] <= isrN;
            end
        end
    end

    // =========================================================
    // Register reads
    // =========================================================
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            ioRdData <= 8'h00;
            ioRdOe_n <= 1'b1;
        end
        else
        begin
            ioRdOe_n <= !(ioRd && ctrlHit);
            if (portSel)
                ioRdData <= mask_q[ctrlSel];
            else
                ioRdData <= readIsr_q[ctrlSel] ? isr_q[ctrlSel] : pending_request_vector[ctrlSel];
        end
    end

endmodule : cvip_pair

// file: hw/cvip_vector_fmt.sv
`timescale 1ns/1ps
// =============================================================
// Acknowledge byte formatter
// =============================================================
module cvip_vector_fmt
(
    input  wire cvip_pkg::cvip_cfg_s cfg,
    input  wire logic [2:0]          idx,
    input  wire logic [1:0]          byteNum,
    output logic [7:0]               vecByte
);
    import cvip_pkg::*;

    // Byte for the given pulse; two-pulse uses only its second pulse
    always_comb
    begin
        vecByte = 8'h00;
        if (cfg.twoPulse)
        begin
            vecByte = {cfg.vecHi[7:3], idx};
        end
        else
        begin
            unique case (byteNum)
                2'h0: vecByte = CALL_OPCODE;
                2'h1:
                begin
                    // Equal spacing from one port_block_origin
                    if (cfg.interval4)
                        vecByte = {cfg.vecLo, idx, 2'b00};
                    else
                        vecByte = {cfg.vecLo[2:1], idx, 3'b000};
                end
                2'h2: vecByte = cfg.vecHi;
                default: vecByte = 8'h00;
            endcase
        end
    end

endmodule : cvip_vector_fmt

// file: include/cvip_pkg.sv
// =============================================================
// Shared constants and types for the cascaded interrupt pair
// =============================================================
package cvip_pkg;

    // =========================================================
    // Port map inside the sixteen-port block
    // =========================================================
    localparam logic [3:0] MASTER_CTRL_PORT_LO   = 4'h0;
    localparam logic [3:0] MASTER_CTRL_PORT_HI   = 4'h1;
    localparam logic [3:0] ONBOARD_SLAVE_PORT_LO = 4'h2;
    localparam logic [3:0] ONBOARD_SLAVE_PORT_HI = 4'h3;

    // =========================================================
    // Command word fields
    // =========================================================
    localparam int CMD_INIT_BIT   = 4;
    localparam int CMD_SELECT_BIT = 3;
    localparam int INIT_NEEDW4    = 0;
    localparam int INIT_SINGLE    = 1;
    localparam int INIT_INTERVAL4 = 2;
    localparam int MODE_TWOPULSE  = 0;
    localparam int MODE_AEOI      = 1;
    localparam int READ_ENABLE    = 1;
    localparam int READ_INSERVICE = 0;

    // Priority command codes, bits 7:5 of a priority command
    localparam logic [2:0] PRI_AEOI_ROT_OFF = 3'h0;
    localparam logic [2:0] PRI_EOI_NONSPEC  = 3'h1;
    localparam logic [2:0] PRI_EOI_SPEC     = 3'h3;
    localparam logic [2:0] PRI_AEOI_ROT_ON  = 3'h4;
    localparam logic [2:0] PRI_ROT_NONSPEC  = 3'h5;
    localparam logic [2:0] PRI_SET          = 3'h6;
    localparam logic [2:0] PRI_ROT_SPEC     = 3'h7;

    // =========================================================
    // Acknowledge constants and reset values
    // =========================================================
    localparam logic [7:0] CALL_OPCODE   = 8'hcd;
    localparam logic [2:0] SLAVE_INPUT   = 3'h1;
    localparam logic [2:0] LOWPRI_RESET  = 3'h7;
    localparam logic [2:0] SPURIOUS_IDX  = 3'h7;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [1:0] ACKCFG_THREE  = 2'h0;
    localparam logic [1:0] ACKCFG_TWO    = 2'h1;
    localparam logic [1:0] ACKCFG_NODRV  = 2'h2;

    typedef enum logic [1:0] {INIT_READY, INIT_WANT2, INIT_WANT3, INIT_WANT4} cvip_init_e;

    // Programmed set-up of one controller
    typedef struct packed {
        logic [7:0] vecHi;
        logic [2:0] vecLo;
        logic       interval4;
        logic       single;
        logic       needW4;
        logic       twoPulse;
        logic       aeoi;
        logic [7:0] cascIn;
    } cvip_cfg_s;

    function automatic logic [7:0] cvip_one_hot(input logic [2:0] idx);
        cvip_one_hot = 8'h01 << idx;
    endfunction : cvip_one_hot

    // Highest-priority in-service bit: {found, index}
    function automatic logic [3:0] cvip_top_isr(input logic [7:0] in_service_vector, input logic [2:0] lowPri);
        logic [2:0] p;
        logic       hit;
        p = 3'h0;
        hit = 1'b0;
        cvip_top_isr = 4'h0;
        for (int k = 1; k <= 8; k++)
        begin
            p = lowPri + 3'(k);
            if (!hit && in_service_vector[p])
            begin
                hit = 1'b1;
                cvip_top_isr = {1'b1, p};
            end
        end
    endfunction : cvip_top_isr

endpackage : cvip_pkg

// file: verif/cvip_host_model.sv
`timescale 1ns/1ps
// ==========
// Host acknowledge driver
module cvip_host_model
(
    input  wire logic       clk,
    input  wire logic [7:0] ackData,
    input  wire logic       ackDataOe_n,
    output logic            intaN
);
    logic [7:0] got [1:3];
    logic       drove [1:3];
    // Idle high between sequences
    initial intaN = 1'b1;
    // Each pulse held three cycles, byte taken just before release
    task automatic ack(input int n);
        for (int p = 1; p <= n; p++)
        begin
            @(posedge clk);
            #2 intaN = 1'b0;
            repeat (3) @(posedge clk);
            #2 got[p] = ackData;
            drove[p] = !ackDataOe_n;
            intaN = 1'b1;
            @(posedge clk);
        end
        #2;
    endtask : ack
endmodule : cvip_host_model

// file: verif/cvip_pair_asserts.sv
`timescale 1ns/1ps
// ==========
// Port checks for the pair
module cvip_pair_asserts
(
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [3:0] boardAddressSwitch,
    input wire logic [7:0] ioAddr,
    input wire logic       ioRd,
    input wire logic       ioRdOe_n,
    input wire logic [7:0] vectorLines,
    input wire logic [1:0] ackCfg,
    input wire logic       intaN,
    input wire logic       intReq,
    input wire logic       ackDataOe_n,
    input wire logic [2:0] cascAddr,
    input wire logic       cascAddrOe_n
);
    import cvip_pkg::*;
    logic hit;
    // Board select, kept apart so properties stay short
    assign hit = ioAddr[7:4] == boardAddressSwitch;
    // Single domain
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!nrst);
    rd_port_block_origin_a: assert property (ioRd && !hit |=> ioRdOe_n)
        else $error("read answered off port_block_origin");
    rd_free_a: assert property (ioRd && hit && ioAddr[3:2] != 2'h0 |=> ioRdOe_n)
        else $error("free port answered");
    rd_ctrl_a: assert property (ioRd && hit && ioAddr[3:2] == 2'h0 |=> !ioRdOe_n)
        else $error("controller port silent");
    rd_idle_a: assert property (!ioRd |=> ioRdOe_n)
        else $error("read data without request");
    ack_rel_a: assert property (intaN |=> ackDataOe_n)
        else $error("data driven outside pulse");
    casc_off_a: assert property ((ackCfg == ACKCFG_NODRV) [*2] |-> cascAddrOe_n)
        else $error("cascade driven in no-drive setting");
    casc_one_a: assert property (!cascAddrOe_n |-> cascAddr != SLAVE_INPUT)
        else $error("input one cascaded on bus");
    ack_blk_a: assert property ($fell(intaN) && $stable(vectorLines) |=> !intReq)
        else $error("request not blocked by in-service");
endmodule : cvip_pair_asserts

bind cvip_pair cvip_pair_asserts u_cvip_pair_asserts
(
    .clk(clk), .nrst(nrst), .boardAddressSwitch(boardAddressSwitch), .ioAddr(ioAddr),
    .ioRd(ioRd), .ioRdOe_n(ioRdOe_n), .vectorLines(vectorLines), .ackCfg(ackCfg),
    .intaN(intaN), .intReq(intReq), .ackDataOe_n(ackDataOe_n), .cascAddr(cascAddr),
    .cascAddrOe_n(cascAddrOe_n)
);

// file: verif/tb_cvip_pair.sv
`timescale 1ns/1ps
// ==========
// Bench for the interrupt pair
module tb_cvip_pair;
    import cvip_pkg::*;
    localparam logic [3:0] SW = 4'ha;
    localparam logic [7:0] B = 8'ha0;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] ioAddr = 8'h00;
    logic [7:0] ioWrData = 8'h00;
    logic       ioWr = 1'b0;
    logic       ioRd = 1'b0;
    logic [7:0] mLines = 8'h00;
    logic [7:0] slv = 8'h00;
    logic [1:0] ackCfg = ACKCFG_THREE;
    logic [7:0] ioRdData, ackData;
    logic       ioRdOe_n, intaN, intReq, ackDataOe_n, cascAddrOe_n;
    logic [2:0] cascAddr;
    int         mismatches = 0;
    int         checks_done = 0;
    // 50 MHz
    always #10 clk = ~clk;
    // Slave inputs come from slv, VI1 among them
    cvip_pair u_cvip_pair
    (
        .boardAddressSwitch(SW), .clk(clk), .nrst(nrst), .ioAddr(ioAddr),
        .ioWrData(ioWrData), .ioWr(ioWr), .ioRd(ioRd), .ioRdData(ioRdData),
        .ioRdOe_n(ioRdOe_n), .vectorLines({mLines[7:2], slv[3], mLines[0]}),
        .timerOutputTwo(slv[0]), .receiveReadyFlag(slv[1]), .parReceiveReadyFlag(slv[2]),
        .timerOutputThree(slv[4]), .transmitReadyFlag(slv[5]),
        .parTransmitReadyFlag(slv[6]), .timerOutputFour(slv[7]), .ackCfg(ackCfg),
        .intaN(intaN), .intReq(intReq), .ackData(ackData), .ackDataOe_n(ackDataOe_n),
        .cascAddr(cascAddr), .cascAddrOe_n(cascAddrOe_n)
    );
    cvip_host_model u_cvip_host_model
    (
        .clk(clk), .ackData(ackData), .ackDataOe_n(ackDataOe_n), .intaN(intaN)
    );
    // ==========
    // Helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 ioAddr = a;
        ioWrData = d;
        ioWr = 1'b1;
        @(posedge clk);
        #2 ioWr = 1'b0;
    endtask : wr
    // Data only judged when the board should answer
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic oe);
        @(posedge clk);
        #2 ioAddr = a;
        ioRd = 1'b1;
        @(posedge clk);
        #2 chk({7'h0, ioRdOe_n}, {7'h0, oe});
        if (!oe)
            chk(ioRdData, d);
        ioRd = 1'b0;
    endtask : rd
    task automatic chkq(input logic exp);
        @(posedge clk);
        #2 chk({7'h0, intReq}, {7'h0, exp});
    endtask : chkq
    task automatic ack3(input logic [7:0] lo, input logic [7:0] hi);
        u_cvip_host_model.ack(3);
        chk(u_cvip_host_model.got[1], CALL_OPCODE);
        chk(u_cvip_host_model.got[2], lo);
        chk(u_cvip_host_model.got[3], hi);
    endtask : ack3
    // ==========
    // Scenarios
    task automatic t_three();
        wr(B, 8'hb6);
        wr(B + 8'h1, 8'h12);
        mLines = 8'h08;
        chkq(1'b1);
        ack3(8'hac, 8'h12);
        chkq(1'b0);
        wr(B, 8'h0b);
        rd(B, 8'h08, 1'b0);
        wr(B, 8'h20);
        rd(B, 8'h00, 1'b0);
        mLines = 8'h00;
    endtask : t_three
    // Eight-byte spacing, nesting, then rotated priority mid-run
    task automatic t_eight();
        ackCfg = ACKCFG_TWO;
        wr(B, 8'hb2);
        wr(B + 8'h1, 8'h12);
        mLines = 8'h24;
        ack3(8'h90, 8'h12);
        mLines = 8'h25;
        chkq(1'b1);
        ack3(8'h80, 8'h12);
        mLines = 8'h00;
        wr(B, 8'h20);
        wr(B, 8'h20);
        wr(B, 8'hc2);
        mLines = 8'h21;
        ack3(8'ha8, 8'h12);
        mLines = 8'h00;
        wr(B, 8'h20);
    endtask : t_eight
    // Two-pulse, auto done, every slave input through master input one
    task automatic t_slave();
        ackCfg = ACKCFG_NODRV;
        wr(B, 8'h13);
        wr(B + 8'h1, 8'h40);
        wr(B + 8'h1, 8'h03);
        wr(B + 8'h2, 8'h13);
        wr(B + 8'h3, 8'h88);
        wr(B + 8'h3, 8'h03);
        wr(B, 8'h0b);
        for (int i = 0; i < 8; i++)
        begin
            slv = 8'h01 << i;
            u_cvip_host_model.ack(2);
            chk({7'h0, u_cvip_host_model.drove[1]}, 8'h00);
            chk(u_cvip_host_model.got[2], 8'h88 | 8'(i));
            chkq(1'b1);
            slv = 8'h00;
        end
        rd(B, 8'h00, 1'b0);
    endtask : t_slave
    // Cascaded master input: second pulse left undriven, cascade address is the input
    task automatic t_casc();
        ackCfg = ACKCFG_THREE;
        wr(B, 8'h14);
        wr(B + 8'h1, 8'h12);
        wr(B + 8'h1, 8'h04);
        mLines = 8'h04;
        u_cvip_host_model.ack(3);
        chk(u_cvip_host_model.got[1], CALL_OPCODE);
        chk({7'h0, u_cvip_host_model.drove[2]}, 8'h00);
        chk({5'h0, cascAddr}, 8'h02);
        mLines = 8'h00;
        wr(B, 8'h20);
    endtask : t_casc
    // Off-port_block_origin and free offsets must not reach the mask
    task automatic t_decode();
        wr(B + 8'h1, 8'h5a);
        wr(8'h51, 8'hff);
        foreach (B[k])
            if (k < 4)
                wr(B + 8'h9 + 8'(2 * k), 8'hff);
        rd(B + 8'h1, 8'h5a, 1'b0);
        rd(8'h51, 8'h00, 1'b1);
        rd(B + 8'h8, 8'h00, 1'b1);
    endtask : t_decode
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // Main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        #2 nrst = 1'b1;
        t_three();
        t_eight();
        t_slave();
        t_casc();
        t_decode();
        give_verdict();
    end
    // Hang guard
    initial
    begin
        #1000000;
        mismatches++;
        give_verdict();
    end
endmodule : tb_cvip_pair
